// *** rtl/exec_pkg.sv ***
package exec_pkg;
	// ==========================================================
	// Quarter phases of one instruction cycle
	// ==========================================================
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;

	// ==========================================================
	// Opcode patterns
	// ==========================================================
	localparam logic [13:0] OP_TBL_STORE  = 14'h0003;
	localparam logic [6:0]  OP_TEST_SKIP  = 7'h33;
	localparam logic [7:0]  OP_XOR_LIT    = 8'h0A;
	localparam logic [5:0]  OP_XOR_FILE   = 6'h06;
	localparam logic [7:0]  OP_ADD_PTR    = 8'hE8;
	localparam logic [7:0]  OP_SUB_PTR    = 8'hE9;
	localparam logic [7:0]  OP_PUSH_LIT   = 8'hEA;
	localparam logic [7:0]  OP_MOVE_STACK = 8'hEB;
	localparam logic [15:0] OP_CALL_ACC   = 16'h0014;
	localparam logic [15:0] OP_NOP        = 16'h0000;
	localparam logic [1:0]  PTR_TWO_SEL   = 2'h3;

	// ==========================================================
	// Table store pointer modes
	// ==========================================================
	localparam logic [1:0] TBL_NO_CHANGE = 2'h0;
	localparam logic [1:0] TBL_POST_INC  = 2'h1;
	localparam logic [1:0] TBL_POST_DEC  = 2'h2;
	localparam logic [1:0] TBL_PRE_INC   = 2'h3;

	// ==========================================================
	// Widths, address layout and reset values
	// ==========================================================
	localparam int          PTR_W          = 21;
	localparam int          HOLD_DEPTH     = 8;
	localparam logic [7:0]  INDEX_LIMIT    = 8'h5F;
	localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [11:0] ADDR_ZERO      = 12'h000;
	localparam logic [20:0] PTR_ZERO       = 21'h000000;
	localparam logic [20:0] PTR_STEP       = 21'h000001;

	typedef enum logic [2:0] {
		EXT_ADD_PTR, EXT_SUB_PTR, EXT_ADD_RET, EXT_SUB_RET,
		EXT_PUSH_LIT, EXT_MOVE_FILE, EXT_MOVE_STACK, EXT_CALL_ACC
	} ext_kind_t;

	typedef enum logic [1:0] {ST_EXEC, ST_TBL2, ST_FLUSH1, ST_FLUSH2} exec_state_t;
endpackage

// *** rtl/table_holding_bank.sv ***
module table_holding_bank
	import exec_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_index,
	input  wire logic [7:0] wr_data,
	input  wire logic [2:0] rd_index,
	output logic      [7:0] rd_data
);
	// ==========================================================
	// Eight holding bytes awaiting a program memory write
	// ==========================================================
	logic [7:0] hold_mem [HOLD_DEPTH];

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < HOLD_DEPTH; i++) begin
				hold_mem[i] <= BYTE_ZERO;
			end
			rd_data <= BYTE_ZERO;
		end else begin
			if (wr_en) begin
				hold_mem[wr_index] <= wr_data;
			end
			rd_data <= hold_mem[rd_index];
		end
	end
endmodule // table_holding_bank

// *** rtl/table_write_skip_xor_exec.sv ***
// Contract
// - Table store writes latch byte into holding register picked by pointer bits 2..0.
// - Pointer bit zero selects low byte when clear, high byte when set.
// - Post-increment stores at current pointer, then increments pointer by one.
// - Pre-increment increments pointer first, then stores at the new address.
// - Test-and-skip decoded from 0110 011, access bit, 8-bit register field.
// - Zero register discards prefetched instruction, executing a no-operation cycle.
// - Skipping a two-word instruction takes three cycles, flushing both words.
// - Test reads register in Q2, evaluates in Q3, keeps status flags.
// - Access bit zero uses access bank; one uses bank select register.
// - Access bit zero with extended set: addresses up to 95 are indexed.
// - Literal XOR 0000 1010 XORs accumulator with literal in one cycle.
// - Register XOR decoded from 0001 10, destination, access, register field.
// - Destination zero writes accumulator; one writes file register.
// - Both XORs update only negative and zero flags.
// - Extended set is off after reset, on only with its configuration bit.
// - Eight extra literal pointer instructions are decoded beyond the base set.
// - Add and subtract pointer-two variants request a subroutine return.
module table_write_skip_xor_exec
	import exec_pkg::*;
(
	input  wire logic [0:0]  clk,
	input  wire logic        rst,
	input  wire logic [15:0] instr_word,
	input  wire logic        next_two_word,
	input  wire logic [7:0]  file_rd_data,
	input  wire logic [3:0]  bank_select_reg,
	input  wire logic [11:0] indirect_pointer_two,
	input  wire logic [7:0]  table_latch_byte,
	input  wire logic        ptr_load,
	input  wire logic [20:0] ptr_load_value,
	input  wire logic        extended_set_enable,
	input  wire logic [2:0]  holding_rd_index,
	output logic      [1:0]  q_phase,
	output logic      [7:0]  acc_value,
	output logic             neg_flag,
	output logic             zero_flag,
	output logic      [11:0] file_addr,
	output logic             file_rd_en,
	output logic             file_wr_en,
	output logic      [7:0]  file_wr_data,
	output logic             indexed_access,
	output logic      [20:0] table_address_pointer,
	output logic             table_byte_high,
	output logic      [7:0]  holding_rd_data,
	output logic             discard_fetch,
	output logic             ext_op_strobe,
	output logic      [2:0]  ext_op_kind,
	output logic             return_req,
	output logic             ext_enabled
);
	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [11:0] file_address(input logic access_bit, input logic [7:0] f,
			input logic [3:0] bank, input logic ext_on, input logic [11:0] base);
		if (access_bit) begin
			file_address = {bank, f};
		end else if (ext_on && f <= INDEX_LIMIT) begin
			file_address = base + {4'h0, f};
		end else if (f <= INDEX_LIMIT) begin
			file_address = {ACCESS_LO_BANK, f};
		end else begin
			file_address = {ACCESS_HI_BANK, f};
		end
	endfunction

	function automatic logic [20:0] ptr_step(input logic [20:0] p, input logic down);
		ptr_step = down ? p - PTR_STEP : p + PTR_STEP;
	endfunction

	// ==========================================================
	// State
	// ==========================================================
	exec_state_t state_reg;
	exec_state_t state_next;
	logic [1:0]  q_reg;
	logic [15:0] ir_reg;
	logic [7:0]  opnd_reg;
	logic [7:0]  result_reg;
	logic [7:0]  latch_reg;
	logic        skip_reg;
	logic        two_word_reg;
	logic [7:0]  acc_reg;
	logic        neg_reg;
	logic        zero_reg;
	logic [11:0] file_addr_reg;
	logic        file_rd_en_reg;
	logic        file_wr_en_reg;
	logic [7:0]  file_wr_data_reg;
	logic        indexed_reg;
	logic [20:0] ptr_reg;
	logic [20:0] ptr_next;
	logic        byte_high_reg;
	logic        discard_reg;
	logic        ext_strobe_reg;
	logic [2:0]  ext_kind_reg;
	logic        return_reg;
	logic        ext_en_reg;

	// ==========================================================
	// Decode
	// ==========================================================
	wire [7:0]  f_field   = ir_reg[7:0];
	wire        acc_bit   = ir_reg[8];
	wire        dest_bit  = ir_reg[9];
	wire [1:0]  tbl_mode  = ir_reg[1:0];
	wire        is_tbl    = ir_reg[15:2] == OP_TBL_STORE;
	wire        is_test   = ir_reg[15:9] == OP_TEST_SKIP;
	wire        is_xorlit = ir_reg[15:8] == OP_XOR_LIT;
	wire        is_xorf   = ir_reg[15:10] == OP_XOR_FILE;
	wire        uses_file = is_test || is_xorf;
	wire        is_xor    = is_xorlit || is_xorf;
	wire        ptr_two   = ir_reg[7:6] == PTR_TWO_SEL;
	wire        ext_hit   = ext_en_reg && (ir_reg[15:10] == OP_ADD_PTR[7:2] || ir_reg == OP_CALL_ACC);
	wire        in_exec   = state_reg == ST_EXEC;
	wire        at_q1     = q_reg == Q1;
	wire        at_q2     = q_reg == Q2;
	wire        at_q3     = q_reg == Q3;
	wire        at_q4     = q_reg == Q4;
	wire        hold_we   = state_reg == ST_TBL2 && at_q4;
	wire [11:0] addr_calc = file_address(instr_word[8], instr_word[7:0], bank_select_reg, ext_en_reg,
		indirect_pointer_two);
	wire        idx_calc  = !instr_word[8] && ext_en_reg && instr_word[7:0] <= INDEX_LIMIT;
	wire [7:0]  xor_res   = acc_reg ^ opnd_reg;

	ext_kind_t ext_kind;
	always_comb begin
		case (ir_reg[15:8])
			OP_ADD_PTR:    ext_kind = ptr_two ? EXT_ADD_RET : EXT_ADD_PTR;
			OP_SUB_PTR:    ext_kind = ptr_two ? EXT_SUB_RET : EXT_SUB_PTR;
			OP_PUSH_LIT:   ext_kind = EXT_PUSH_LIT;
			OP_MOVE_STACK: ext_kind = ir_reg[7] ? EXT_MOVE_STACK : EXT_MOVE_FILE;
			default:       ext_kind = EXT_CALL_ACC;
		endcase
	end

	// Skips and the table store's second cycle run no fetched instruction; the word on
	// instr_word is dropped rather than decoded.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				if (at_q4 && is_tbl) begin
					state_next = ST_TBL2;
				end else if (at_q4 && is_test && skip_reg) begin
					state_next = ST_FLUSH1;
				end
			end
			ST_TBL2: begin
				if (at_q4) begin
					state_next = ST_EXEC;
				end
			end
			ST_FLUSH1: begin
				if (at_q4) begin
					state_next = two_word_reg ? ST_FLUSH2 : ST_EXEC;
				end
			end
			default: begin
				if (at_q4) begin
					state_next = ST_EXEC;
				end
			end
		endcase
	end

	// Pre-increment moves the pointer at the end of the first cycle, so the store that
	// follows lands on the new address; post modes move it in the same edge as the store.
	always_comb begin
		ptr_next = ptr_reg;
		if (in_exec && at_q4 && is_tbl && tbl_mode == TBL_PRE_INC) begin
			ptr_next = ptr_step(ptr_reg, 1'b0);
		end else if (hold_we && tbl_mode == TBL_POST_INC) begin
			ptr_next = ptr_step(ptr_reg, 1'b0);
		end else if (hold_we && tbl_mode == TBL_POST_DEC) begin
			ptr_next = ptr_step(ptr_reg, 1'b1);
		end else if (ptr_load && in_exec) begin
			ptr_next = ptr_load_value;
		end
	end

	// ==========================================================
	// Sequencing
	// ==========================================================
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_EXEC;
			q_reg     <= Q1;
			ptr_reg   <= PTR_ZERO;
		end else begin
			state_reg <= state_next;
			q_reg     <= q_reg + 2'h1;
			ptr_reg   <= ptr_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_en_reg <= 1'b0;
		end else begin
			ext_en_reg <= extended_set_enable;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ir_reg         <= OP_NOP;
			file_addr_reg  <= ADDR_ZERO;
			file_rd_en_reg <= 1'b0;
			indexed_reg    <= 1'b0;
			discard_reg    <= 1'b0;
		end else begin
			file_rd_en_reg <= 1'b0;
			discard_reg    <= 1'b0;
			if (at_q1 && in_exec) begin
				ir_reg         <= instr_word;
				file_addr_reg  <= addr_calc;
				indexed_reg    <= idx_calc;
				file_rd_en_reg <= instr_word[15:9] == OP_TEST_SKIP || instr_word[15:10] == OP_XOR_FILE;
			end else if (at_q1 && state_reg != ST_TBL2) begin
				ir_reg      <= OP_NOP;
				discard_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			opnd_reg     <= BYTE_ZERO;
			latch_reg    <= BYTE_ZERO;
			skip_reg     <= 1'b0;
			two_word_reg <= 1'b0;
		end else begin
			if (at_q2) begin
				opnd_reg <= uses_file ? file_rd_data : f_field;
			end
			if (at_q2 && state_reg == ST_TBL2) begin
				latch_reg <= table_latch_byte;
			end
			if (at_q3) begin
				skip_reg     <= is_test && opnd_reg == BYTE_ZERO;
				two_word_reg <= next_two_word;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			result_reg       <= BYTE_ZERO;
			acc_reg          <= BYTE_ZERO;
			neg_reg          <= 1'b0;
			zero_reg         <= 1'b0;
			file_wr_en_reg   <= 1'b0;
			file_wr_data_reg <= BYTE_ZERO;
		end else begin
			file_wr_en_reg <= 1'b0;
			if (at_q3) begin
				result_reg <= xor_res;
			end
			if (at_q4 && in_exec && is_xor) begin
				neg_reg  <= result_reg[7];
				zero_reg <= result_reg == BYTE_ZERO;
				if (is_xorlit || !dest_bit) begin
					acc_reg <= result_reg;
				end else begin
					file_wr_en_reg   <= 1'b1;
					file_wr_data_reg <= result_reg;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			byte_high_reg  <= 1'b0;
			ext_strobe_reg <= 1'b0;
			ext_kind_reg   <= EXT_ADD_PTR;
			return_reg     <= 1'b0;
		end else begin
			ext_strobe_reg <= in_exec && at_q4 && ext_hit;
			return_reg     <= in_exec && at_q4 && ext_hit && (ext_kind == EXT_ADD_RET || ext_kind == EXT_SUB_RET);
			if (in_exec && at_q4 && ext_hit) begin
				ext_kind_reg <= ext_kind;
			end
			if (hold_we) begin
				byte_high_reg <= ptr_reg[0];
			end
		end
	end

	table_holding_bank u_hold (
		.clk      (clk),
		.rst      (rst),
		.wr_en    (hold_we),
		.wr_index (ptr_reg[2:0]),
		.wr_data  (latch_reg),
		.rd_index (holding_rd_index),
		.rd_data  (holding_rd_data)
	);

	assign q_phase               = q_reg;
	assign acc_value             = acc_reg;
	assign neg_flag              = neg_reg;
	assign zero_flag             = zero_reg;
	assign file_addr             = file_addr_reg;
	assign file_rd_en            = file_rd_en_reg;
	assign file_wr_en            = file_wr_en_reg;
	assign file_wr_data          = file_wr_data_reg;
	assign indexed_access        = indexed_reg;
	assign table_address_pointer = ptr_reg;
	assign table_byte_high       = byte_high_reg;
	assign discard_fetch         = discard_reg;
	assign ext_op_strobe         = ext_strobe_reg;
	assign ext_op_kind           = ext_kind_reg;
	assign return_req            = return_reg;
	assign ext_enabled           = ext_en_reg;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire tbl_start = in_exec && at_q4 && is_tbl;
	wire skip_take = in_exec && at_q4 && is_test && skip_reg;

	sequence s_second_cycle;
		(state_reg == ST_TBL2) [*4];
	endsequence
	sequence s_pre_then_store;
		(ptr_reg == $past(ptr_reg) + PTR_STEP) ##3 hold_we;
	endsequence

	a_tbl_two_cycle: assert property (tbl_start |=> s_second_cycle)
		else $error("table store second cycle not four phases");
	a_pre_inc_order: assert property (tbl_start && tbl_mode == TBL_PRE_INC |=> s_pre_then_store)
		else $error("pre-increment did not precede the store");
	a_post_inc_ptr: assert property (hold_we && tbl_mode == TBL_POST_INC |=> ptr_reg == $past(ptr_reg) + PTR_STEP)
		else $error("post-increment pointer wrong");
	a_skip_discard: assert property (skip_take |-> ##2 discard_reg ##4 discard_reg == two_word_reg)
		else $error("skip did not flush the right number of words");
	a_no_skip_nonzero: assert property (in_exec && at_q4 && is_test && !skip_reg |=> state_reg == ST_EXEC)
		else $error("nonzero test skipped");
	a_test_flags_kept: assert property (in_exec && at_q4 && is_test |=> $stable(neg_reg) && $stable(zero_reg))
		else $error("test changed status flags");
	a_xor_flag_value: assert property (in_exec && at_q4 && is_xor |=> neg_reg == result_reg[7]
		&& zero_reg == (result_reg == BYTE_ZERO))
		else $error("xor flags wrong");
	a_xor_lit_acc: assert property (in_exec && at_q2 && is_xorlit |=> ##2 acc_reg == ($past(acc_reg, 3) ^ $past(f_field, 3)))
		else $error("literal xor result wrong");
	a_ext_reset_off: assert property ($fell(rst) |-> !ext_en_reg)
		else $error("extended set on after reset");
	a_index_addr: assert property (at_q1 && in_exec && idx_calc |=> file_addr_reg == indirect_pointer_two
		+ {4'h0, $past(instr_word[7:0])})
		else $error("indexed address wrong");
endmodule // table_write_skip_xor_exec

// *** verif/fetch_mem_model.sv ***
module fetch_mem_model (
	input  wire logic        clk,
	input  wire logic [11:0] file_addr,
	input  wire logic        file_rd_en,
	input  wire logic        file_wr_en,
	input  wire logic [7:0]  file_wr_data,
	output logic      [7:0]  file_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Data memory
	// ==========================================================
	logic [7:0] mem [0:4095];
	logic [7:0] last_reg;

	// Outside a read the bus is undriven; showing the inverse of the last byte stops a late sample passing by luck.
	assign file_rd_data = file_rd_en ? mem[file_addr] : ~last_reg;

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		last_reg = 8'h00;
	end

	always @(posedge clk) begin
		if (file_rd_en)
			last_reg <= mem[file_addr];
		if (file_wr_en)
			mem[file_addr] <= file_wr_data;
	end
endmodule // fetch_mem_model

// *** verif/table_write_skip_xor_exec_tb.sv ***
module table_write_skip_xor_exec_tb
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals
	// ==========================================================
	logic [0:0]  clk;
	logic        rst, next_two_word, ptr_load, extended_set_enable;
	logic [15:0] instr_word;
	logic [7:0]  file_rd_data, table_latch_byte, acc_value, file_wr_data, holding_rd_data;
	logic [3:0]  bank_select_reg;
	logic [11:0] indirect_pointer_two, file_addr;
	logic [20:0] ptr_load_value, table_address_pointer;
	logic [2:0]  holding_rd_index, ext_op_kind, last_kind;
	logic [1:0]  q_phase;
	logic        neg_flag, zero_flag, file_rd_en, file_wr_en, indexed_access, table_byte_high;
	logic        discard_fetch, ext_op_strobe, return_req, ext_enabled;
	int          err_total, samples_checked, disc_cnt, strobe_cnt, ret_cnt, s, d, r;

	typedef struct {logic [15:0] word; logic [11:0] addr; logic [7:0] fval, acc, fexp; logic n, z;} xor_row_t;
	typedef struct {logic [1:0] mode; logic [20:0] start, fin; logic [7:0] latch; logic [2:0] idx; logic high;} tbl_row_t;
	typedef struct {logic [15:0] word; logic [2:0] kind; logic ret;} ext_row_t;

	// Addresses follow the access bit: low access bank up to 5F, upper bank above, bank select 2 otherwise.
	xor_row_t xor_rows [6] = '{
		'{16'h0AAF, 12'h000, 8'h00, 8'hAF, 8'h00, 1'b1, 1'b0},
		'{16'h0AAF, 12'h000, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1},
		'{16'h0AB5, 12'h000, 8'h00, 8'hB5, 8'h00, 1'b1, 1'b0},
		'{16'h1810, 12'h010, 8'hAF, 8'h1A, 8'hAF, 1'b0, 1'b0},
		'{16'h1B20, 12'h220, 8'h1A, 8'h1A, 8'h00, 1'b0, 1'b1},
		'{16'h1A80, 12'hF80, 8'h75, 8'h1A, 8'h6F, 1'b0, 1'b0}};
	tbl_row_t tbl_rows [4] = '{
		'{2'h0, 21'h000010, 21'h000010, 8'h11, 3'h0, 1'b0},
		'{2'h1, 21'h00A356, 21'h00A357, 8'h55, 3'h6, 1'b0},
		'{2'h2, 21'h000025, 21'h000024, 8'h22, 3'h5, 1'b1},
		'{2'h3, 21'h01389A, 21'h01389B, 8'h34, 3'h3, 1'b1}};
	ext_row_t ext_rows [8] = '{
		'{16'hE805, EXT_ADD_PTR, 1'b0}, '{16'hE905, EXT_SUB_PTR, 1'b0},
		'{16'hE8C5, EXT_ADD_RET, 1'b1}, '{16'hE9C3, EXT_SUB_RET, 1'b1},
		'{16'hEA12, EXT_PUSH_LIT, 1'b0}, '{16'hEB05, EXT_MOVE_FILE, 1'b0},
		'{16'hEB85, EXT_MOVE_STACK, 1'b0}, '{16'h0014, EXT_CALL_ACC, 1'b0}};

	table_write_skip_xor_exec table_write_skip_xor_exec_i (.clk(clk), .rst(rst), .instr_word(instr_word),
		.next_two_word(next_two_word), .file_rd_data(file_rd_data), .bank_select_reg(bank_select_reg),
		.indirect_pointer_two(indirect_pointer_two), .table_latch_byte(table_latch_byte), .ptr_load(ptr_load),
		.ptr_load_value(ptr_load_value), .extended_set_enable(extended_set_enable),
		.holding_rd_index(holding_rd_index), .q_phase(q_phase), .acc_value(acc_value), .neg_flag(neg_flag),
		.zero_flag(zero_flag), .file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data), .indexed_access(indexed_access),
		.table_address_pointer(table_address_pointer), .table_byte_high(table_byte_high),
		.holding_rd_data(holding_rd_data), .discard_fetch(discard_fetch), .ext_op_strobe(ext_op_strobe),
		.ext_op_kind(ext_op_kind), .return_req(return_req), .ext_enabled(ext_enabled));

	fetch_mem_model fetch_mem_model_i (.clk(clk), .file_addr(file_addr), .file_rd_en(file_rd_en),
		.file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .file_rd_data(file_rd_data));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rst === 1'b0) begin
			if (discard_fetch === 1'b1) disc_cnt++;
			if (return_req === 1'b1) ret_cnt++;
			if (ext_op_strobe === 1'b1) begin
				strobe_cnt++;
				last_kind = ext_op_kind;
			end
		end
	end

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask

	// The word is offered only on the taking edge, so a late sample sees a no-operation instead.
	task automatic issue(input logic [15:0] word, input int n);
		int k;
		k = 0;
		while (q_phase !== Q1 && k < 8) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 8) begin
			check(32'h1, 32'h0);
			summarize();
		end else begin
			instr_word = word;
			@(posedge clk);
			#1;
			instr_word = OP_NOP;
			repeat (n - 1) begin
				@(posedge clk);
				#1;
			end
		end
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{err_total, samples_checked, disc_cnt, strobe_cnt, ret_cnt} = '0;
		{rst, instr_word, next_two_word, ptr_load, ptr_load_value, extended_set_enable} = '0;
		rst = 1'b1;
		bank_select_reg = 4'h2;
		indirect_pointer_two = 12'h100;
		table_latch_byte = 8'h00;
		holding_rd_index = 3'h0;
		last_kind = 3'h0;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		check({q_phase, acc_value, neg_flag, zero_flag}, 32'h0);
		check({ext_enabled, table_address_pointer}, 32'h0);
		foreach (xor_rows[i]) begin
			fetch_mem_model_i.mem[xor_rows[i].addr] = xor_rows[i].fval;
			// One extra edge lets the file write, pulsed after the fourth phase, reach memory.
			issue(xor_rows[i].word, 5);
			check(acc_value, xor_rows[i].acc);
			check({neg_flag, zero_flag}, {xor_rows[i].n, xor_rows[i].z});
			check(fetch_mem_model_i.mem[xor_rows[i].addr], xor_rows[i].fexp);
			check(indexed_access, 1'b0);
		end
		extended_set_enable = 1'b1;
		issue(OP_NOP, 4);
		check(ext_enabled, 1'b1);
		fetch_mem_model_i.mem[12'h110] = 8'h3C;
		issue(16'h1810, 4);
		check({indexed_access, acc_value}, {1'b1, 8'h26});
		foreach (ext_rows[i]) begin
			s = strobe_cnt;
			r = ret_cnt;
			issue(ext_rows[i].word, 4);
			issue(16'hF000, 4);
			check(strobe_cnt - s, 1);
			check(last_kind, ext_rows[i].kind);
			check(ret_cnt - r, ext_rows[i].ret);
		end
		extended_set_enable = 1'b0;
		issue(OP_NOP, 4);
		s = strobe_cnt;
		issue(16'hE8C5, 5);
		check({ext_enabled, 31'(strobe_cnt - s)}, 32'h0);
		issue(16'h0A26, 4);
		fetch_mem_model_i.mem[12'h230] = 8'h05;
		d = disc_cnt;
		issue(16'h6730, 4);
		check({neg_flag, zero_flag}, 2'b01);
		issue(16'h0A0F, 4);
		check({acc_value, 24'(disc_cnt - d)}, {8'h0F, 24'h0});
		fetch_mem_model_i.mem[12'h230] = 8'h00;
		issue(16'h6730, 4);
		check({neg_flag, zero_flag}, 2'b00);
		issue(16'h0AFF, 4);
		issue(16'h0AF0, 4);
		check({acc_value, 24'(disc_cnt - d)}, {8'hFF, 24'h1});
		next_two_word = 1'b1;
		issue(16'h6730, 4);
		issue(16'h0AFF, 4);
		issue(16'h0AFF, 4);
		issue(16'h0A0F, 4);
		check({acc_value, 24'(disc_cnt - d)}, {8'hF0, 24'h3});
		next_two_word = 1'b0;
		foreach (tbl_rows[i]) begin
			ptr_load_value = tbl_rows[i].start;
			ptr_load = 1'b1;
			@(posedge clk);
			#1;
			ptr_load = 1'b0;
			table_latch_byte = tbl_rows[i].latch;
			issue({OP_TBL_STORE, tbl_rows[i].mode}, 6);
			table_latch_byte = ~tbl_rows[i].latch;
			repeat (2) @(posedge clk);
			#1;
			check(table_address_pointer, tbl_rows[i].fin);
			check(table_byte_high, tbl_rows[i].high);
			holding_rd_index = tbl_rows[i].idx;
			repeat (2) @(posedge clk);
			#1;
			check(holding_rd_data, tbl_rows[i].latch);
		end
		holding_rd_index = 3'h2;
		repeat (2) @(posedge clk);
		#1;
		check(holding_rd_data, 8'h00);
		summarize();
	end
endmodule // table_write_skip_xor_exec_tb
